// ==== core/wsg_top.sv ====
// wait-state generator: APB register file, range decode and counter control.
// assumes APB3 signalling on the machine clock and a core that pulses acc_start_i per external access.
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module wsg_top #(
	parameter int unsigned ACC_ADDR_W = wsg_pkg::PADDR_W
) (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [wsg_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [wsg_pkg::DATA_W-1:0] pwdata_i,
	output logic [wsg_pkg::DATA_W-1:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic acc_start_i,
	input wire logic [2:0] acc_space_i,
	input wire logic [ACC_ADDR_W-1:0] acc_addr_i,
	input wire logic ext_ready_i,
	output logic acc_wait_o,
	output logic acc_done_o,
	output logic ws_clk_off_o
);

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [wsg_pkg::FIELD_W-1:0] field_of(
		input logic [wsg_pkg::REG_W-1:0] cfg,
		input int unsigned lsb
	);
		field_of = cfg[lsb +: wsg_pkg::FIELD_W];
	endfunction

	function automatic logic [wsg_pkg::CNT_W-1:0] scaled(
		input logic [wsg_pkg::FIELD_W-1:0] base,
		input logic mult
	);
		// doubling a 3-bit base caps at fourteen
		scaled = mult ? {base, 1'b0} : {1'b0, base};
	endfunction

	function automatic logic addr_hit(
		input logic [wsg_pkg::ADDR_W-1:0] a,
		input logic [wsg_pkg::ADDR_W-1:0] reg_addr
	);
		addr_hit = (a == reg_addr);
	endfunction

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		logic [wsg_pkg::REG_W-1:0] cfg;
		logic mult;
		logic [wsg_pkg::DATA_W-1:0] rdata;
	} wsg_top_state_t;

	wsg_top_state_t s;
	wsg_top_state_t next_s;

	logic hit_cfg;
	logic hit_ctrl;
	logic setup_rd;
	logic access_wr;
	logic [wsg_pkg::FIELD_W-1:0] base_sel;
	logic [wsg_pkg::CNT_W-1:0] count_sel;
	logic [wsg_pkg::DATA_W-1:0] rd_mux;

	wsg_cnt_if cif ();

	assign hit_cfg = addr_hit(paddr_i, wsg_pkg::CFG_ADDR);
	assign hit_ctrl = addr_hit(paddr_i, wsg_pkg::CTRL_ADDR);
	assign setup_rd = psel_i && !penable_i && !pwrite_i;
	assign access_wr = psel_i && penable_i && pwrite_i;

	// ****************************************
	// range decode
	// ****************************************
	always_comb begin
		base_sel = field_of(s.cfg, wsg_pkg::IO_LSB);
		unique case (acc_space_i)
			wsg_pkg::WSG_SPACE_IO: begin
				base_sel = field_of(s.cfg, wsg_pkg::IO_LSB);
			end
			wsg_pkg::WSG_SPACE_DATA: begin
				if (acc_addr_i[wsg_pkg::PAGE_HALF_BIT]) begin
					base_sel = field_of(s.cfg, wsg_pkg::DHI_LSB);
				end else begin
					base_sel = field_of(s.cfg, wsg_pkg::DLO_LSB);
				end
			end
			wsg_pkg::WSG_SPACE_PROG: begin
				if (s.cfg[wsg_pkg::PROG_RANGE_SEL_BIT]) begin
					if (acc_addr_i[wsg_pkg::EXT_HALF_BIT]) begin
						base_sel = field_of(s.cfg, wsg_pkg::PHI_LSB);
					end else begin
						base_sel = field_of(s.cfg, wsg_pkg::PLO_LSB);
					end
				end else if (acc_addr_i[wsg_pkg::PAGE_HALF_BIT]) begin
					base_sel = field_of(s.cfg, wsg_pkg::PHI_LSB);
				end else begin
					base_sel = field_of(s.cfg, wsg_pkg::PLO_LSB);
				end
			end
			default: begin
				// an illegal space code takes the I/O count
				base_sel = field_of(s.cfg, wsg_pkg::IO_LSB);
			end
		endcase
		count_sel = scaled(base_sel, s.mult);
	end

	// ****************************************
	// register file
	// ****************************************
	always_comb begin
		rd_mux = '0;
		if (hit_cfg) begin
			rd_mux = {{(wsg_pkg::DATA_W-wsg_pkg::REG_W){1'b0}}, s.cfg};
		end else if (hit_ctrl) begin
			// reserved control bits read as zero
			rd_mux[wsg_pkg::MULT_BIT] = s.mult;
		end
	end

	always_comb begin
		next_s = s;
		// read data captured in setup so the access phase answers from a flop
		if (setup_rd) begin
			next_s.rdata = rd_mux;
		end
		if (access_wr && hit_cfg) begin
			next_s.cfg = pwdata_i[wsg_pkg::REG_W-1:0];
		end
		if (access_wr && hit_ctrl) begin
			next_s.mult = pwdata_i[wsg_pkg::MULT_BIT];
		end
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			s.cfg <= wsg_pkg::CFG_RESET;
			s.mult <= wsg_pkg::CTRL_MULT_RESET;
			s.rdata <= '0;
		end else begin
			s <= next_s;
		end
	end

	// ****************************************
	// counter control
	// ****************************************
	// a start while a stretch is running is ignored by the counter
	assign cif.load = acc_start_i;
	assign cif.count = count_sel;
	assign cif.gate_off = ((s.cfg & wsg_pkg::CFG_COUNT_MASK) == '0);
	assign cif.ext_ready = ext_ready_i;

	wsg_counter u_counter (
		.core_clk_i(core_clk_i),
		.nrst_i(nrst_i),
		.cif(cif)
	);

	// ****************************************
	// outputs
	// ****************************************
	assign prdata_o = s.rdata;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i && penable_i && !hit_cfg && !hit_ctrl;
	assign acc_wait_o = cif.busy && !cif.done;
	assign acc_done_o = cif.done;
	assign ws_clk_off_o = cif.gate_off;

endmodule // wsg_top
`default_nettype wire

// ==== include/wsg_pkg.sv ====
// wait-state generator constants: register map, field layout, reset values, states.
// assumes a 20 MHz machine clock and an APB slave port with 12-bit byte addresses.
package wsg_pkg;

	// ****************************************
	// register map
	// ****************************************
	localparam int unsigned ADDR_W = 12;
	localparam int unsigned REG_W = 16;
	localparam int unsigned DATA_W = 32;
	// offsets are word indices, byte address is four times the index
	localparam int unsigned CFG_IDX = 'h28;
	localparam int unsigned CTRL_IDX = 'h2b;
	localparam logic [ADDR_W-1:0] CFG_ADDR = ADDR_W'(CFG_IDX * 4);
	localparam logic [ADDR_W-1:0] CTRL_ADDR = ADDR_W'(CTRL_IDX * 4);

	// ****************************************
	// field layout and reset values
	// ****************************************
	localparam int unsigned FIELD_W = 3;
	localparam int unsigned CNT_W = 4;
	localparam int unsigned PROG_RANGE_SEL_BIT = 15;
	localparam int unsigned IO_LSB = 12;
	localparam int unsigned DHI_LSB = 9;
	localparam int unsigned DLO_LSB = 6;
	localparam int unsigned PHI_LSB = 3;
	localparam int unsigned PLO_LSB = 0;
	localparam int unsigned MULT_BIT = 0;
	localparam logic [REG_W-1:0] CFG_RESET = 16'h7fff;
	localparam logic CTRL_MULT_RESET = 1'h0;
	localparam logic [REG_W-1:0] CFG_COUNT_MASK = 16'h7fff;

	// ****************************************
	// address decoding
	// ****************************************
	localparam int unsigned PADDR_W = 23;
	localparam int unsigned PAGE_HALF_BIT = 15;
	localparam int unsigned EXT_HALF_BIT = 22;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [2:0] {
		WSG_SPACE_IO = 3'h1,
		WSG_SPACE_DATA = 3'h2,
		WSG_SPACE_PROG = 3'h4
	} wsg_space_t;

	typedef enum logic [2:0] {
		WSG_ST_IDLE = 3'h1,
		WSG_ST_COUNT = 3'h2,
		WSG_ST_HOLD = 3'h4
	} wsg_state_t;

endpackage

// ==== include/wsg_cnt_if.sv ====
// carrier between the register/decode logic and the wait-state counter.
// assumes both ends run on the same machine clock.
`timescale 1ns/1ps
`default_nettype none
interface wsg_cnt_if;
	logic load;
	logic [wsg_pkg::CNT_W-1:0] count;
	logic gate_off;
	logic ext_ready;
	logic busy;
	logic done;
	modport ctl (output load, output count, output gate_off, output ext_ready, input busy, input done);
	modport cnt (input load, input count, input gate_off, input ext_ready, output busy, output done);
endinterface
`default_nettype wire

// ==== core/wsg_counter.sv ====
// wait-state down-counter: counts the programmed states, then holds for ready.
// assumes load is only acted on while idle.
`timescale 1ns/1ps
`default_nettype none
module wsg_counter (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	wsg_cnt_if.cnt cif
);

	// ****************************************
	// state
	// ****************************************
	typedef struct packed {
		wsg_pkg::wsg_state_t st;
		logic [wsg_pkg::CNT_W-1:0] cnt;
	} wsg_cnt_state_t;

	wsg_cnt_state_t s;
	wsg_cnt_state_t next_s;

	always_comb begin
		next_s = s;
		unique case (s.st)
			wsg_pkg::WSG_ST_IDLE: begin
				if (cif.load) begin
					// zero states, or all-zero map with the counter parked: straight to ready
					if (cif.gate_off || cif.count == '0) begin
						next_s.st = wsg_pkg::WSG_ST_HOLD;
					end else begin
						next_s.st = wsg_pkg::WSG_ST_COUNT;
						next_s.cnt = cif.count;
					end
				end
			end
			wsg_pkg::WSG_ST_COUNT: begin
				next_s.cnt = s.cnt - 1'b1;
				if (s.cnt == wsg_pkg::CNT_W'(1)) begin
					next_s.st = wsg_pkg::WSG_ST_HOLD;
				end
			end
			wsg_pkg::WSG_ST_HOLD: begin
				// stretch past the programmed maximum until the far side is ready
				if (cif.ext_ready) begin
					next_s.st = wsg_pkg::WSG_ST_IDLE;
				end
			end
			default: begin
				next_s.st = wsg_pkg::WSG_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (!nrst_i) begin
			s.st <= wsg_pkg::WSG_ST_IDLE;
			s.cnt <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign cif.busy = (s.st != wsg_pkg::WSG_ST_IDLE);
	assign cif.done = (s.st == wsg_pkg::WSG_ST_HOLD) && cif.ext_ready;

endmodule // wsg_counter
`default_nettype wire

// ==== tb/wsg_checker.sv ====
// port checker for the wait-state generator top.
// assumes it is bound onto wsg_top, one clock, synchronous reset.
`timescale 1ns/1ps
`default_nettype none
module wsg_checker (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [wsg_pkg::ADDR_W-1:0] paddr_i,
	input wire logic [wsg_pkg::DATA_W-1:0] pwdata_i,
	input wire logic acc_start_i,
	input wire logic ext_ready_i,
	input wire logic acc_wait_o,
	input wire logic acc_done_o,
	input wire logic ws_clk_off_o
);
	default clocking @(posedge core_clk_i); endclocking
	default disable iff (!nrst_i);
	logic [4:0] wcnt;
	// restarts when ready drops, so slow devices never trip the bound
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || !acc_wait_o || !ext_ready_i) begin
			wcnt <= 5'h0;
		end else begin
			wcnt <= wcnt + 5'h1;
		end
	end
	sequence s_cfg_wr;
		psel_i && penable_i && pwrite_i && paddr_i == wsg_pkg::CFG_ADDR;
	endsequence
	sequence s_idle_start;
		acc_start_i && !acc_wait_o && !acc_done_o;
	endsequence
	chk_max_fourteen: assert property (acc_wait_o && ext_ready_i |-> wcnt < 5'he)
		else $error("stretch beyond fourteen");
	chk_done_needs_ready: assert property (acc_done_o |-> ext_ready_i)
		else $error("done without ready");
	chk_done_ends_wait: assert property (acc_done_o |-> !acc_wait_o)
		else $error("wait high in done cycle");
	chk_done_one_pulse: assert property (acc_done_o |=> !acc_done_o)
		else $error("done longer than one cycle");
	chk_start_answers: assert property (s_idle_start |=> acc_wait_o || acc_done_o)
		else $error("start not answered");
	chk_clk_off_zero: assert property (s_cfg_wr ##0 pwdata_i[14:0] == 15'h0 |=> ws_clk_off_o)
		else $error("clock not parked");
	chk_clk_on_count: assert property (s_cfg_wr ##0 pwdata_i[14:0] != 15'h0 |=> !ws_clk_off_o)
		else $error("clock parked with counts");
	chk_reset_clk_on: assert property ($rose(nrst_i) |-> !ws_clk_off_o)
		else $error("clock parked after reset");
endmodule // wsg_checker
bind wsg_top wsg_checker chk (.*);
`default_nettype wire

// ==== tb/wsg_ext_dev.sv ====
// far-side device: holds ready low for slow_i cycles of each access.
// assumes the machine clock of the generator.
`timescale 1ns/1ps
`default_nettype none
module wsg_ext_dev (
	input wire logic core_clk_i,
	input wire logic nrst_i,
	input wire logic acc_start_i,
	input wire logic acc_wait_i,
	input wire logic [4:0] slow_i,
	output logic ready_o
);
	logic [4:0] cnt;
	always_ff @(posedge core_clk_i) begin
		if (!nrst_i || acc_start_i) begin
			cnt <= 5'h0;
		end else if (acc_wait_i && cnt != 5'h1f) begin
			cnt <= cnt + 5'h1;
		end
	end
	assign ready_o = cnt >= slow_i;
endmodule // wsg_ext_dev
`default_nettype wire

// ==== tb/wsg_top_tb.sv ====
// self-checking bench for the wait-state generator.
// assumes the checker is bound and the device model answers ready.
`timescale 1ns/1ps
`default_nettype none
module wsg_top_tb;
	logic clk, nrst, psel, pen, pwr, pready, pslverr, start, wt, done, clkoff, rdy, err;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [2:0] sp;
	logic [22:0] addr;
	logic [4:0] slow;
	int mismatches = 0;
	int n_compared = 0;
	wsg_top uut (.core_clk_i(clk), .nrst_i(nrst), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
		.paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
		.acc_start_i(start), .acc_space_i(sp), .acc_addr_i(addr), .ext_ready_i(rdy),
		.acc_wait_o(wt), .acc_done_o(done), .ws_clk_off_o(clkoff));
	wsg_ext_dev dev (.core_clk_i(clk), .nrst_i(nrst), .acc_start_i(start), .acc_wait_i(wt),
		.slow_i(slow), .ready_o(rdy));
	initial begin
		clk = 0;
		forever #25 clk = ~clk;
	end
	task automatic print_verdict();
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		n_compared++;
		if (got !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pen <= 1'b0;
		pwr <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		// answer taken only at the edge that samples ready high
		for (i = 0; i < 20; i++) begin
			@(posedge clk);
			if (pready === 1'b1) begin
				rd = prdata;
				err = pslverr;
				break;
			end
		end
		if (i == 20) begin
			mismatches++;
			print_verdict();
		end
		psel <= 1'b0;
		pen <= 1'b0;
		@(posedge clk);
	endtask
	task automatic acc(input logic [2:0] s, input logic [22:0] a, input logic [31:0] exp);
		int i, n;
		sp <= s;
		addr <= a;
		start <= 1'b1;
		@(posedge clk);
		start <= 1'b0;
		n = 0;
		for (i = 0; i < 40; i++) begin
			@(negedge clk);
			if (done === 1'b1) break;
			if (wt === 1'b1) n++;
		end
		if (i == 40) begin
			mismatches++;
			print_verdict();
		end
		@(posedge clk);
		chk("stretch", exp, 32'(n));
	endtask
	initial begin
		nrst = 1'b0;
		psel = 1'b0;
		pen = 1'b0;
		pwr = 1'b0;
		paddr = 12'h0;
		pwdata = 32'h0;
		start = 1'b0;
		sp = 3'h1;
		addr = 23'h0;
		slow = 5'h0;
		repeat (10) @(posedge clk);
		nrst <= 1'b1;
		apb(1'b0, wsg_pkg::CFG_ADDR, 32'h0);
		chk("cfg", 32'h7fff, rd);
		apb(1'b0, wsg_pkg::CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h0, rd);
		acc(3'h1, 23'h0, 32'h7);
		apb(1'b1, wsg_pkg::CTRL_ADDR, 32'hffff);
		apb(1'b0, wsg_pkg::CTRL_ADDR, 32'h0);
		chk("ctrl", 32'h1, rd);
		acc(3'h1, 23'h0, 32'he);
		apb(1'b1, wsg_pkg::CTRL_ADDR, 32'h0);
		apb(1'b0, 12'ha4, 32'h0);
		chk("slverr", 32'h1, {31'h0, err});
		apb(1'b1, wsg_pkg::CFG_ADDR, 32'h14e5);
		acc(3'h1, 23'h0, 32'h1);
		// an illegal space code falls back to the i/o count
		acc(3'h3, 23'h0, 32'h1);
		acc(3'h2, 23'h8000, 32'h2);
		acc(3'h2, 23'h7fff, 32'h3);
		acc(3'h4, 23'h18000, 32'h4);
		acc(3'h4, 23'h17fff, 32'h5);
		apb(1'b1, wsg_pkg::CFG_ADDR, 32'h94e5);
		apb(1'b0, wsg_pkg::CFG_ADDR, 32'h0);
		chk("cfg", 32'h94e5, rd);
		acc(3'h4, 23'h400000, 32'h4);
		acc(3'h4, 23'h3fffff, 32'h5);
		acc(3'h4, 23'h8000, 32'h5);
		slow <= 5'h5;
		acc(3'h2, 23'h8000, 32'h5);
		apb(1'b1, wsg_pkg::CFG_ADDR, 32'h0);
		chk("clk_off", 32'h1, {31'h0, clkoff});
		acc(3'h1, 23'h0, 32'h5);
		slow <= 5'h0;
		acc(3'h1, 23'h0, 32'h0);
		print_verdict();
	end
endmodule // wsg_top_tb
`default_nettype wire
